// ===== logic/tpg_pkg.sv
// Constants for the 16-bit pulse generator / capture timer.
// Assumes a classic Wishbone slave with 32-bit data, byte addresses.
package tpg_pkg;
  localparam int          CNT_W        = 16;
  localparam int          AW           = 8;
  // Register byte offsets
  localparam logic [7:0]  ADR_RUN      = 8'h00;
  localparam logic [7:0]  ADR_MODE     = 8'h04;
  localparam logic [7:0]  ADR_FFCR     = 8'h08;
  localparam logic [7:0]  ADR_DUTY     = 8'h0C;
  localparam logic [7:0]  ADR_PERIOD   = 8'h10;
  localparam logic [7:0]  ADR_CAPT     = 8'h14;
  localparam logic [7:0]  ADR_STATUS   = 8'h18;
  localparam logic [7:0]  ADR_IEN      = 8'h1C;
  // Run register fields
  localparam int          RUN_RUN_B    = 0;
  localparam int          RUN_PRUN_B   = 2;
  localparam int          RUN_DBUF_B   = 7;
  // Mode register fields
  localparam int          MOD_CLK_LO   = 0;
  localparam int          MOD_CLR_B    = 2;
  localparam int          MOD_CPM_LO   = 3;
  // Flop control fields
  localparam int          FF_CTL_LO    = 0;
  localparam int          FF_CAPT_B    = 4;
  localparam int          FF_DUTY_B    = 2;
  localparam int          FF_PER_B     = 3;
  localparam logic [1:0]  FF_CODE_INV  = 2'h0;
  localparam logic [1:0]  FF_CODE_SET  = 2'h1;
  localparam logic [1:0]  FF_CODE_CLR  = 2'h2;
  // Capture modes
  localparam logic [1:0]  CPM_OFF      = 2'h0;
  localparam logic [1:0]  CPM_RISE     = 2'h1;
  localparam logic [1:0]  CPM_PWIDTH   = 2'h2;
  // Interrupt enable bits
  localparam int          IE_DUTY_B    = 0;
  localparam int          IE_PER_B     = 1;
  // Prescaler taps: clock select 1,2,3 divide by two to the power of tap plus one (4, 16, 256)
  localparam int          PS_W         = 8;
  localparam int          PS_TAP1      = 1;
  localparam int          PS_TAP2      = 3;
  localparam int          PS_TAP3      = 7;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [31:0] RD_UNMAPPED  = 32'h00000000;
endpackage

// ===== logic/tpg_prescaler.sv
// Free-running prescaler giving one-cycle ticks for the counter clock.
// Assumes the run control bit comes from the same clock domain.
`timescale 1ns/1ps
module tpg_prescaler (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       prun,
  input  wire logic [1:0] sel,
  output logic            tick
);
  import tpg_pkg::*;

  logic [PS_W-1:0] div_ff;
  logic [PS_W-1:0] nxt_div;
  logic            hit;

  always_comb begin
    nxt_div = div_ff + 8'h01;
    if (sel == 2'h1) begin
      hit = (div_ff[PS_TAP1:0] == {(PS_TAP1+1){1'b1}});
    end else if (sel == 2'h2) begin
      hit = (div_ff[PS_TAP2:0] == {(PS_TAP2+1){1'b1}});
    end else if (sel == 2'h3) begin
      hit = (div_ff[PS_TAP3:0] == {(PS_TAP3+1){1'b1}});
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn || !prun) begin
      div_ff <= '0;
      tick   <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick   <= hit;
    end
  end
endmodule

// ===== logic/tpg_timer.sv
// 16-bit timer with duty/period compares, toggle flop and capture register.
// Assumes a classic Wishbone master on mclk; trigger pin is asynchronous.
// Functional notes
// - Toggle flop inverts on duty or period match
// - Toggle flop state drives pulse output pin
// - Initial flop state sets pulse polarity
// - Buffered duty loads on period match
// - Compare values one through zero meaning 65536
// - Zero compare matches on counter overflow
// - Mode low bits select prescaler clock
// - Rising trigger edge captures the counter
// - Rising trigger edge raises external interrupt
// - Both enable bits allow both inversions
// - Capture may invert the toggle flop
// - Pulse-width mode interrupts on falling edge
`timescale 1ns/1ps
module tpg_timer (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [tpg_pkg::AW-1:0] wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   trigger_in_pin,
  output logic                        pulse_out_pin,
  output logic                        ext_trigger_irq,
  output logic                        duty_match_irq,
  output logic                        period_match_irq
);
  import tpg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]       run_ff;
  logic [5:0]       mode_ff;
  logic [4:0]       ffcr_ff;
  logic [15:0]      duty_buf_ff;
  logic [15:0]      duty_compare_reg;
  logic [15:0]      period_compare_reg;
  logic [15:0]      first_capture_reg;
  logic [15:0]      up_counter;
  logic             toggle_flop;
  logic [1:0]       ien_ff;
  logic [2:0]       sts_ff;
  logic             trg_s1_ff;
  logic             trg_s2_ff;
  logic             trg_d_ff;
  logic             tick;
  logic             wr;
  logic             rd_ack;
  logic             ovf;
  logic             duty_hit;
  logic             per_hit;
  logic             rise;
  logic             fall;
  logic             capt;
  logic             clr_mode;
  logic [1:0]       capture_mode_sel;
  logic             invert_on_duty_match;
  logic             invert_on_period_match;
  logic [15:0]      nxt_cnt;

  assign wr                     = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_ack                 = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign capture_mode_sel       = mode_ff[MOD_CPM_LO+1:MOD_CPM_LO];
  assign clr_mode               = mode_ff[MOD_CLR_B];
  assign invert_on_duty_match   = ffcr_ff[FF_DUTY_B];
  assign invert_on_period_match = ffcr_ff[FF_PER_B];

  ////////////////////////////////////////////////////////////////////////
  // Counter clock
  // Prescaler tap select
  tpg_prescaler u_ps (
    .mclk (mclk),
    .rstn (rstn),
    .prun (run_ff[RUN_PRUN_B]),
    .sel  (mode_ff[MOD_CLK_LO+1:MOD_CLK_LO]),
    .tick (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Trigger pin synchroniser and edges
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      trg_s1_ff <= 1'b0;
      trg_s2_ff <= 1'b0;
      trg_d_ff  <= 1'b0;
    end else begin
      trg_s1_ff <= trigger_in_pin;
      trg_s2_ff <= trg_s1_ff;
      trg_d_ff  <= trg_s2_ff;
    end
  end
  assign rise = trg_s2_ff && !trg_d_ff;
  assign fall = !trg_s2_ff && trg_d_ff;
  assign capt = rise && (capture_mode_sel != CPM_OFF);

  ////////////////////////////////////////////////////////////////////////
  // Compare matches
  assign ovf     = tick && (up_counter == CNT_MAX);
  assign duty_hit = tick && ((duty_compare_reg == CNT_ZERO) ? (up_counter == CNT_MAX)
                    : (up_counter == duty_compare_reg - 16'h0001));
  assign per_hit  = tick && ((period_compare_reg == CNT_ZERO) ? (up_counter == CNT_MAX)
                    : (up_counter == period_compare_reg - 16'h0001));

  always_comb begin
    nxt_cnt = up_counter + 16'h0001;
    if (per_hit && clr_mode) begin
      nxt_cnt = CNT_ZERO;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn || !run_ff[RUN_RUN_B]) begin
      up_counter <= CNT_ZERO;
    end else if (tick) begin
      up_counter <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      first_capture_reg <= CNT_ZERO;
    end else if (capt) begin
      first_capture_reg <= up_counter;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Duty buffer and active compare registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      duty_buf_ff        <= CNT_ZERO;
      duty_compare_reg   <= CNT_ZERO;
      period_compare_reg <= CNT_ZERO;
    end else begin
      if (wr && wb_adr_i == ADR_DUTY) begin
        duty_buf_ff <= wb_dat_i[15:0];
      end
      if (wr && wb_adr_i == ADR_PERIOD) begin
        period_compare_reg <= wb_dat_i[15:0];
      end
      if (run_ff[RUN_DBUF_B]) begin
        if (per_hit) begin
          duty_compare_reg <= duty_buf_ff;
        end
      end else if (wr && wb_adr_i == ADR_DUTY) begin
        duty_compare_reg <= wb_dat_i[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Toggle flop
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      toggle_flop <= 1'b0;
    end else if (wr && wb_adr_i == ADR_FFCR && wb_dat_i[1:0] == FF_CODE_CLR) begin
      toggle_flop <= 1'b0;
    end else if (wr && wb_adr_i == ADR_FFCR && wb_dat_i[1:0] == FF_CODE_SET) begin
      toggle_flop <= 1'b1;
    end else if (wr && wb_adr_i == ADR_FFCR && wb_dat_i[1:0] == FF_CODE_INV) begin
      toggle_flop <= !toggle_flop;
    end else if ((duty_hit && invert_on_duty_match) || (per_hit && invert_on_period_match)
                 || (capt && ffcr_ff[FF_CAPT_B])) begin
      toggle_flop <= !toggle_flop;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pulse_out_pin <= 1'b0;
    end else begin
      pulse_out_pin <= toggle_flop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      run_ff  <= 8'h00;
      mode_ff <= 6'h00;
      ffcr_ff <= 5'h00;
      ien_ff  <= 2'h0;
    end else if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == ADR_RUN) begin
        run_ff <= wb_dat_i[7:0];
      end else if (wb_adr_i == ADR_MODE) begin
        mode_ff <= wb_dat_i[5:0];
      end else if (wb_adr_i == ADR_FFCR) begin
        ffcr_ff <= {wb_dat_i[4:2], 2'h3};
      end else if (wb_adr_i == ADR_IEN) begin
        ien_ff <= wb_dat_i[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event pulses and sticky status (set wins over write-one-clear)
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ext_trigger_irq  <= 1'b0;
      duty_match_irq   <= 1'b0;
      period_match_irq <= 1'b0;
      sts_ff           <= 3'h0;
    end else begin
      ext_trigger_irq  <= (capture_mode_sel == CPM_PWIDTH) ? fall : rise;
      duty_match_irq   <= duty_hit && ien_ff[IE_DUTY_B];
      period_match_irq <= per_hit && ien_ff[IE_PER_B];
      sts_ff <= (sts_ff & ~((wr && wb_adr_i == ADR_STATUS) ? wb_dat_i[2:0] : 3'h0))
                | {per_hit, duty_hit,
                   (capture_mode_sel == CPM_PWIDTH) ? fall : rise};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone answer: one wait state, ack for one cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= RD_UNMAPPED;
    end else begin
      wb_ack_o <= rd_ack;
      if (rd_ack && !wb_we_i) begin
        if (wb_adr_i == ADR_RUN) begin
          wb_dat_o <= {24'h000000, run_ff};
        end else if (wb_adr_i == ADR_MODE) begin
          wb_dat_o <= {26'h0000000, mode_ff};
        end else if (wb_adr_i == ADR_FFCR) begin
          wb_dat_o <= {27'h0000000, ffcr_ff};
        end else if (wb_adr_i == ADR_DUTY) begin
          wb_dat_o <= {16'h0000, duty_buf_ff};
        end else if (wb_adr_i == ADR_PERIOD) begin
          wb_dat_o <= {16'h0000, period_compare_reg};
        end else if (wb_adr_i == ADR_CAPT) begin
          wb_dat_o <= {16'h0000, first_capture_reg};
        end else if (wb_adr_i == ADR_STATUS) begin
          wb_dat_o <= {12'h000, up_counter, toggle_flop, sts_ff};
        end else if (wb_adr_i == ADR_IEN) begin
          wb_dat_o <= {30'h00000000, ien_ff};
        end else begin
          wb_dat_o <= RD_UNMAPPED;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Pin follows flop
  pin_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
    pulse_out_pin == $past(toggle_flop)) else $error("pin not following flop");
  duty_inv_a: assert property (@(posedge mclk) disable iff (!rstn)
    (duty_hit && invert_on_duty_match && !per_hit && !capt && !wr) |=> toggle_flop != $past(toggle_flop))
    else $error("no inversion on duty match");
  no_inv_a: assert property (@(posedge mclk) disable iff (!rstn)
    (!invert_on_duty_match && !invert_on_period_match && !ffcr_ff[FF_CAPT_B] && !wr)
    |=> toggle_flop == $past(toggle_flop)) else $error("spurious inversion");
  dbuf_copy_a: assert property (@(posedge mclk) disable iff (!rstn)
    (run_ff[RUN_DBUF_B] && per_hit) |=> duty_compare_reg == $past(duty_buf_ff))
    else $error("duty buffer not copied");
  zero_ovf_a: assert property (@(posedge mclk) disable iff (!rstn)
    (period_compare_reg == CNT_ZERO) |-> (per_hit == ovf)) else $error("zero compare wrong");
  capt_val_a: assert property (@(posedge mclk) disable iff (!rstn)
    capt |=> first_capture_reg == $past(up_counter)) else $error("capture missed");
  trig_irq_a: assert property (@(posedge mclk) disable iff (!rstn)
    (rise && capture_mode_sel != CPM_PWIDTH) |=> ext_trigger_irq) else $error("no trigger irq");
  fall_irq_a: assert property (@(posedge mclk) disable iff (!rstn)
    (fall && capture_mode_sel == CPM_PWIDTH) |=> ext_trigger_irq) else $error("no fall irq");
  per_irq_a: assert property (@(posedge mclk) disable iff (!rstn)
    period_match_irq |-> $past(per_hit) && $past(ien_ff[IE_PER_B])) else $error("bad period irq");
  cnt_clr_a: assert property (@(posedge mclk) disable iff (!rstn)
    (per_hit && clr_mode && run_ff[RUN_RUN_B]) |=> up_counter == CNT_ZERO)
    else $error("counter not cleared");
  ppg_cov_c: cover property (@(posedge mclk) per_hit && invert_on_period_match);
  dbuf_cov_c: cover property (@(posedge mclk) run_ff[RUN_DBUF_B] && per_hit);
  capt_cov_c: cover property (@(posedge mclk) capt && ffcr_ff[FF_CAPT_B]);
endmodule

// ===== tb/timer_pulse_gen_capture_bench.sv
// Self-checking bench for the pulse generator and capture timer.
// Assumes the Wishbone map and timing given in the design package.
`timescale 1ns/1ps
module timer_pulse_gen_capture_bench;
  import tpg_pkg::*;
  logic          mclk, rstn, cyc, stb, we;
  logic [AW-1:0] adr;
  logic [3:0]    sel;
  logic [31:0]   wdat, rdat, q;
  logic          ack, trig, pout, ext_irq, duty_irq, per_irq;
  int            errors = 0;
  int            checks_done = 0;
  int            n_ext = 0;
  int            n_duty = 0;
  int            n_per = 0;
  int            d, p, d2, w, c0, c1;

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (ext_irq === 1'b1) n_ext <= n_ext + 1;
    if (duty_irq === 1'b1) n_duty <= n_duty + 1;
    if (per_irq === 1'b1) n_per <= n_per + 1;
  end

  tpg_timer i_tpg_timer (
    .mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .trigger_in_pin(trig), .pulse_out_pin(pout),
    .ext_trigger_irq(ext_irq), .duty_match_irq(duty_irq),
    .period_match_irq(per_irq)
  );
  tpg_pin_partner i_tpg_pin_partner (
    .mclk(mclk), .pulse_out_pin(pout), .trigger_in_pin(trig)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Classic single cycle, held until ack is sampled; a lost ack is left to the watchdog
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] dt);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= dt;
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_out(input logic v, input int lim);
    int n;
    n = 0;
    while (pout !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
    check("pulse_out", pout, v);
  endtask

  function automatic int hi_exp(int dd, int pp);
    return (pp - dd) * 4;
  endfunction

  function automatic logic rate_ok(int s, int dl);
    int dv;
    dv = (s == 1) ? 4 : (s == 2) ? 16 : 256;
    if (s == 0) return dl == 0;
    return dl >= 1024 / dv - 1 && dl <= 1028 / dv + 1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole run needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    conclude;
  end

  initial begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'hF;
    wdat = '0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    void'($urandom(28));
    xfer(ADR_STATUS, 1'b0, 32'h0);
    check("status", q, 32'h0);
    xfer(8'h40, 1'b1, 32'hFFFFFFFF);
    xfer(8'h40, 1'b0, 32'h0);
    check("unmapped", q, RD_UNMAPPED);
    xfer(ADR_FFCR, 1'b1, 32'h01);
    wait_out(1'b1, 8);
    xfer(ADR_STATUS, 1'b0, 32'h0);
    check("flop set", q[3], 1'b1);
    xfer(ADR_FFCR, 1'b1, 32'h02);
    wait_out(1'b0, 8);
    check("flop clear", pout, 1'b0);
    xfer(ADR_FFCR, 1'b1, 32'h00);
    wait_out(1'b1, 8);
    check("flop invert", pout, 1'b1);
    $display("test reset and flop codes done");
    d = $urandom_range(20, 2);
    p = d + $urandom_range(30, 3);
    xfer(ADR_RUN, 1'b1, 32'h00);
    xfer(ADR_DUTY, 1'b1, d);
    xfer(ADR_PERIOD, 1'b1, p);
    xfer(ADR_RUN, 1'b1, 32'h80);
    xfer(ADR_FFCR, 1'b1, 32'h0E);
    xfer(ADR_MODE, 1'b1, 32'h05);
    xfer(ADR_IEN, 1'b1, 32'h02);
    xfer(ADR_RUN, 1'b1, 32'h85);
    n_duty = 0;
    n_per = 0;
    wait_out(1'b1, p * 4 + 40);
    wait_out(1'b0, p * 4 + 40);
    @(posedge mclk);
    check("high width", i_tpg_pin_partner.hi_len, hi_exp(d, p));
    wait_out(1'b1, p * 4 + 40);
    @(posedge mclk);
    check("period", i_tpg_pin_partner.rise_gap, p * 4);
    check("duty irq masked", n_duty, 0);
    check("period irq", n_per > 0, 1'b1);
    xfer(ADR_IEN, 1'b1, 32'h03);
    wait_out(1'b0, p * 4 + 40);
    d2 = d + 1;
    xfer(ADR_DUTY, 1'b1, d2);
    wait_out(1'b1, p * 4 + 40);
    wait_out(1'b0, p * 4 + 40);
    @(posedge mclk);
    check("old duty kept", i_tpg_pin_partner.hi_len, hi_exp(d, p));
    wait_out(1'b1, p * 4 + 40);
    wait_out(1'b0, p * 4 + 40);
    @(posedge mclk);
    check("new duty", i_tpg_pin_partner.hi_len, hi_exp(d2, p));
    check("duty irq", n_duty > 0, 1'b1);
    xfer(ADR_RUN, 1'b1, 32'h00);
    xfer(ADR_FFCR, 1'b1, 32'h02);
    $display("test pulse pattern done");
    for (int s = 0; s < 4; s++) begin
      xfer(ADR_MODE, 1'b1, s);
      xfer(ADR_RUN, 1'b1, 32'h05);
      xfer(ADR_STATUS, 1'b0, 32'h0);
      c0 = q[19:4];
      repeat (1024) @(posedge mclk);
      xfer(ADR_STATUS, 1'b0, 32'h0);
      c1 = q[19:4];
      check("count rate", rate_ok(s, (c1 - c0) & 16'hFFFF), 1'b1);
    end
    $display("test clock select done");
    xfer(ADR_MODE, 1'b1, 32'h09);
    xfer(ADR_FFCR, 1'b1, 32'h12);
    xfer(ADR_IEN, 1'b1, 32'h02);
    n_ext = 0;
    n_per = 0;
    i_tpg_pin_partner.drive(1'b1);
    wait_out(1'b1, 20);
    xfer(ADR_CAPT, 1'b0, 32'h0);
    c0 = q[15:0];
    xfer(ADR_STATUS, 1'b0, 32'h0);
    c1 = q[19:4];
    check("capture", (c1 - c0 & 16'hFFFF) <= 8, 1'b1);
    check("trigger irq", n_ext, 1);
    w = $urandom_range(40, 8);
    xfer(ADR_PERIOD, 1'b1, (c0 + w) & 16'hFFFF);
    xfer(ADR_FFCR, 1'b1, 32'h0B);
    wait_out(1'b0, w * 4 + 20);
    @(posedge mclk);
    // Width is w-1 ticks plus the part of a tick before the first count
    c1 = i_tpg_pin_partner.hi_len - w * 4 + 4;
    check("one-shot", c1 >= 0 && c1 <= 3, 1'b1);
    check("one-shot irq", n_per, 1);
    xfer(ADR_FFCR, 1'b1, 32'h03);
    i_tpg_pin_partner.drive(1'b0);
    $display("test one-shot done");
    for (int m = 1; m < 4; m++) begin
      xfer(ADR_MODE, 1'b1, (m << 3) | 1);
      n_ext = 0;
      i_tpg_pin_partner.drive(1'b1);
      repeat (12) @(posedge mclk);
      check("irq on rise", n_ext, int'(m != 2));
      i_tpg_pin_partner.drive(1'b0);
      repeat (12) @(posedge mclk);
      check("irq per pulse", n_ext, 1);
    end
    $display("test capture modes done");
    conclude;
  end
endmodule

// ===== tb/tpg_pin_partner.sv
// Pin partner: drives the trigger pin and measures the pulse output.
// Assumes mclk is the timer clock and the pins sit on the block's ports.
`timescale 1ns/1ps
module tpg_pin_partner (
  input  wire logic mclk,
  input  wire logic pulse_out_pin,
  output logic      trigger_in_pin
);
  int   hi_cnt   = 0;
  int   hi_len   = 0;
  int   gap_cnt  = 0;
  int   rise_gap = 0;
  logic prev     = 1'b0;

  initial trigger_in_pin = 1'b0;

  always @(posedge mclk) begin
    prev <= pulse_out_pin;
    gap_cnt <= gap_cnt + 1;
    if (pulse_out_pin === 1'b1)
      hi_cnt <= hi_cnt + 1;
    if (pulse_out_pin === 1'b1 && prev !== 1'b1) begin
      rise_gap <= gap_cnt;
      gap_cnt <= 1;
      hi_cnt <= 1;
    end
    if (pulse_out_pin !== 1'b1 && prev === 1'b1)
      hi_len <= hi_cnt;
  end

  task automatic drive(input logic v);
    @(posedge mclk);
    trigger_in_pin <= v;
  endtask
endmodule
